/* File: hw/dsbc_pkg.sv */
// package for the dram space and burst configuration block
package dsbc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses on the avalon slave)
    localparam int         ADDR_W          = 4;
    localparam logic [3:0] OFF_CONTROL     = 4'h0;
    localparam logic [3:0] OFF_STATUS      = 4'h4;
    localparam int         CTRL_W          = 16;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;

    // control field positions
    localparam int SEL_LSB     = 8;
    localparam int SEL_MSB     = 10;
    localparam int BURST_BIT   = 7;
    localparam int HOLD_BIT    = 6;
    localparam int DMA_OPT_BIT = 5;

    // status field positions
    localparam int ST_HELD_BIT   = 0;
    localparam int ST_LOW_BIT    = 1;
    localparam int ST_AREA_LSB   = 4;
    localparam int ST_CDRAM_BIT  = 8;
    localparam int ST_CSDRAM_BIT = 9;
    localparam int ST_MODE_BIT   = 10;

    ////////////////////////////////////////////////////////////////////////
    // space-select encodings
    localparam logic [2:0] SEL_NORMAL     = 3'h0;
    localparam logic [2:0] SEL_AREA2      = 3'h1;
    localparam logic [2:0] SEL_AREA23     = 3'h2;
    localparam logic [2:0] SEL_AREA2TO5   = 3'h3;
    localparam logic [2:0] SEL_CONT_SDRAM = 3'h4;
    localparam logic [2:0] SEL_SDRAM_MODE = 3'h5;
    localparam logic [2:0] SEL_PROHIBITED = 3'h6;
    localparam logic [2:0] SEL_CONT_DRAM  = 3'h7;

    // first external area that can hold dram
    localparam logic [2:0] FIRST_AREA = 3'h2;
    localparam int         NUM_AREAS  = 4;

    ////////////////////////////////////////////////////////////////////////
    // decoded space configuration
    typedef struct packed {
        logic [3:0] dram_area;   // bit n: area n+2 is dram-type space
        logic       cont_dram;
        logic       cont_sdram;
        logic       mode_set;
    } dsbc_space_t;

    // one external access as seen by the bus state machine
    typedef struct packed {
        logic       start;       // first cycle of an external access
        logic       done;        // last cycle of that access
        logic [2:0] area;        // external area number
        logic       dma_single;  // single-address dma transfer
        logic       internal;    // internal register access
    } dsbc_access_t;

endpackage

/* File: hw/dsbc_space_decode.sv */
// space-select decoder: maps the three-bit select onto areas 2 to 5
`timescale 1ns/1ps
module dsbc_space_decode #(
    parameter bit SDRAM_SUPPORT = 1'b1
) (
    input  wire logic [2:0]          i_sel,    // space-select field
    output dsbc_pkg::dsbc_space_t    o_space   // decoded space layout
);
    import dsbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pure decode; the prohibited code reads back but maps to normal space
    always_comb begin
        o_space = '0;
        case (i_sel)
            SEL_NORMAL: begin
                o_space.dram_area = 4'h0;
            end
            SEL_AREA2: begin
                o_space.dram_area = 4'h1;
            end
            SEL_AREA23: begin
                o_space.dram_area = 4'h3;
            end
            SEL_AREA2TO5: begin
                o_space.dram_area = 4'hf;
            end
            SEL_CONT_SDRAM: begin
                // parts without sdram support fall back to normal space
                if (SDRAM_SUPPORT) begin
                    o_space.dram_area  = 4'hf;
                    o_space.cont_sdram = 1'b1;
                end
            end
            SEL_SDRAM_MODE: begin
                // mode-register setting: no data access is burst-able
                if (SDRAM_SUPPORT) begin
                    o_space.mode_set = 1'b1;
                end
            end
            SEL_PROHIBITED: begin
                o_space.dram_area = 4'h0;
            end
            SEL_CONT_DRAM: begin
                o_space.dram_area = 4'hf;
                o_space.cont_dram = 1'b1;
            end
            default: begin
                o_space = '0;
            end
        endcase
    end

endmodule

/* File: hw/dsbc_top.sv */
// dram space and burst configuration: register, row-strobe hold, burst grant
`timescale 1ns/1ps
module dsbc_top #(
    parameter bit SDRAM_SUPPORT = 1'b1
) (
    input  wire logic                        i_sys_clk,          // 100 mhz clock
    input  wire logic                        i_rst_b,            // async reset, low
    // avalon-mm slave
    input  wire logic [dsbc_pkg::ADDR_W-1:0] i_avs_address,      // byte address
    input  wire logic                        i_avs_read,         // read request
    input  wire logic                        i_avs_write,        // write request
    input  wire logic [31:0]                 i_avs_writedata,    // write data
    input  wire logic [3:0]                  i_avs_byteenable,   // byte lanes
    output logic [31:0]                      o_avs_readdata,     // read data
    output logic                             o_avs_waitrequest,  // stall
    // external access in progress, from the bus state machine
    input  dsbc_pkg::dsbc_access_t           i_access,           // access info
    // decisions towards the external bus logic
    output dsbc_pkg::dsbc_space_t            o_space,            // area layout
    output logic                             o_access_dram,      // access is dram
    output logic                             o_burst_ok,         // burst allowed
    output logic                             o_row_strobe_b,     // row strobe, low
    output logic                             o_row_held          // strobe held low
);
    import dsbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // elaboration check
    generate
        if (SDRAM_SUPPORT !== 1'b0 && SDRAM_SUPPORT !== 1'b1) begin : g_bad_param
            $error("dsbc_top: SDRAM_SUPPORT must be 0 or 1");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // declarations
    typedef enum logic [1:0] {
        RS_IDLE,
        RS_ACTIVE,
        RS_HELD
    } dsbc_row_state_t;

    // register bus side
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic              ack_reg;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic              req;
    logic              wr_fire;
    logic              sel_ctrl;
    logic              sel_status;

    // config views
    dsbc_space_t       space;
    logic              burst_en;
    logic              hold_low;
    logic              dma_opt;

    // decisions
    logic              down_eff;
    logic              hit_dram;
    logic              grant;

    // row strobe
    dsbc_row_state_t   row_reg;
    dsbc_row_state_t   row_next;
    logic              strobe_b_reg;
    logic              held_reg;

    // access flags
    logic              dram_acc_reg;
    logic              burst_reg;
    logic [31:0]       status_word;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true when the access targets an area marked as dram-type space
    function automatic logic area_is_dram(input dsbc_space_t sp,
                                          input logic [2:0]  area);
        logic [2:0] idx;
        idx = area - FIRST_AREA;

        if (area < FIRST_AREA || area > FIRST_AREA + 3'(NUM_AREAS - 1)) begin
            return 1'b0;
        end
        return sp.dram_area[idx[1:0]];
    endfunction

    // merge a 16-bit register with write data under two byte lanes
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        logic [15:0] res;
        res = old;

        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // avalon slave handshake
    // one wait cycle per request: the read word is latched in the first
    // cycle so it is stable at the edge where waitrequest is seen low
    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_reg;
    assign wr_fire           = i_avs_write & ack_reg;
    assign sel_ctrl          = (i_avs_address == OFF_CONTROL);
    assign sel_status        = (i_avs_address == OFF_STATUS);

    // acknowledge toggles high for exactly one cycle per request
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    // every bit is stored as written, the prohibited select code included;
    // the decoder rather than the register keeps it harmless
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_fire && sel_ctrl) begin
            ctrl_next = lane_merge(ctrl_reg, i_avs_writedata, i_avs_byteenable);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // field views
    assign burst_en = ctrl_reg[BURST_BIT];
    assign hold_low = ctrl_reg[HOLD_BIT];
    assign dma_opt  = ctrl_reg[DMA_OPT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // space decode
    dsbc_space_decode #(
        .SDRAM_SUPPORT (SDRAM_SUPPORT)
    ) u_decode (
        .i_sel   (ctrl_reg[SEL_MSB:SEL_LSB]),
        .o_space (space)
    );

    assign o_space = space;

    ////////////////////////////////////////////////////////////////////////
    // effective hold-low mode
    // hold only counts with bursts on, and never in continuous sdram space
    // clearing either bit while held must lift the strobe the next edge
    assign down_eff = burst_en & hold_low & ~space.cont_sdram;

    // access start that lands in dram-type space
    assign hit_dram = i_access.start & area_is_dram(space, i_access.area);

    ////////////////////////////////////////////////////////////////////////
    // burst grant
    // the dma option only narrows single-address dma; dual-address and other masters
    // see burst enable alone, so the option cannot leak into them
    always_comb begin
        grant = 1'b0;
        if (burst_en && !space.mode_set) begin
            if (i_access.dma_single) begin
                grant = dma_opt;
            end else begin
                grant = 1'b1;
            end
        end
    end

    // burst and dram flags are latched at access start and held to the end
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dram_acc_reg <= 1'b0;
            burst_reg    <= 1'b0;
        end else if (i_access.start) begin
            dram_acc_reg <= hit_dram;
            burst_reg    <= hit_dram & grant;
        end else if (i_access.done) begin
            dram_acc_reg <= 1'b0;
            burst_reg    <= 1'b0;
        end
    end

    assign o_access_dram = dram_acc_reg;
    assign o_burst_ok    = burst_reg;

    ////////////////////////////////////////////////////////////////////////
    // row strobe state machine
    // active: a dram access owns the strobe; held: strobe parked low while
    // a normal or internal access runs, waiting for the next dram access
    always_comb begin
        row_next = row_reg;
        case (row_reg)
            RS_IDLE: begin
                if (hit_dram) begin
                    row_next = RS_ACTIVE;
                end
            end

            RS_ACTIVE: begin
                if (i_access.done) begin
                    if (down_eff) begin
                        row_next = RS_HELD;
                    end else begin
                        row_next = RS_IDLE;
                    end
                end
            end

            RS_HELD: begin
                if (!down_eff) begin
                    // hold-low or burst cleared: lift the strobe at once
                    row_next = RS_IDLE;
                end else if (hit_dram) begin
                    row_next = RS_ACTIVE;
                end
            end

            default: begin
                row_next = RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            row_reg <= RS_IDLE;
        end else begin
            row_reg <= row_next;
        end
    end

    // strobe pins come from flops so they never glitch between states
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strobe_b_reg <= 1'b1;
            held_reg     <= 1'b0;
        end else begin
            strobe_b_reg <= (row_next == RS_IDLE);
            held_reg     <= (row_next == RS_HELD);
        end
    end

    assign o_row_strobe_b = strobe_b_reg;
    assign o_row_held     = held_reg;

    ////////////////////////////////////////////////////////////////////////
    // status word: live view of the decoded layout and the strobe
    always_comb begin
        status_word                                  = '0;
        status_word[ST_HELD_BIT]                     = held_reg;
        status_word[ST_LOW_BIT]                      = ~strobe_b_reg;
        status_word[ST_AREA_LSB+NUM_AREAS-1:ST_AREA_LSB] = space.dram_area;
        status_word[ST_CDRAM_BIT]                    = space.cont_dram;
        status_word[ST_CSDRAM_BIT]                   = space.cont_sdram;
        status_word[ST_MODE_BIT]                     = space.mode_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    // unmapped offsets read as zero; writes to them are dropped
    always_comb begin
        rdata_next = rdata_reg;
        if (i_avs_read && !ack_reg) begin
            if (sel_ctrl) begin
                rdata_next = {16'h0000, ctrl_reg};
            end else if (sel_status) begin
                rdata_next = status_word;
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_avs_readdata = rdata_reg;

    // edo output-enable wiring is a board concern; nothing here drives it
    // so burst grants assume the system wired it when edo parts are fitted

endmodule

/* File: tb/dsbc_top_chk.sv */
// assertion checker for the dram space and burst configuration block
`timescale 1ns/1ps
module dsbc_top_chk #(
    parameter bit SDRAM_SUPPORT = 1'b1
) (
    input wire logic                        i_sys_clk,         // clock
    input wire logic                        i_rst_b,           // async reset, low
    input wire logic [dsbc_pkg::ADDR_W-1:0] i_avs_address,     // byte address
    input wire logic                        i_avs_read,        // read request
    input wire logic                        i_avs_write,       // write request
    input wire logic [31:0]                 i_avs_writedata,   // write data
    input wire logic [3:0]                  i_avs_byteenable,  // byte lanes
    input wire logic [31:0]                 o_avs_readdata,    // read data
    input wire logic                        o_avs_waitrequest, // stall
    input dsbc_pkg::dsbc_access_t           i_access,          // access info
    input dsbc_pkg::dsbc_space_t            o_space,           // area layout
    input wire logic                        o_access_dram,     // access is dram
    input wire logic                        o_burst_ok,        // burst allowed
    input wire logic                        o_row_strobe_b,    // row strobe, low
    input wire logic                        o_row_held         // strobe held
);
    import dsbc_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    logic [15:0] ctrl_reg;
    logic        wr_ctl;
    logic        hit;
    logic        be;
    logic        grant;
    logic [2:0]  ai;
    logic [6:0]  exp_space;

    ////////////////////////////////////////////////////////////////////////
    // shadow control register and decisions the block must reach
    assign wr_ctl = i_avs_write & ~o_avs_waitrequest & (i_avs_address == OFF_CONTROL);
    assign ai     = i_access.area - FIRST_AREA;
    assign hit    = (i_access.area >= 3'h2) && (i_access.area <= 3'h5) && exp_space[ai[1:0] + 3];
    assign be     = ctrl_reg[BURST_BIT];
    assign grant  = be && (!i_access.dma_single || ctrl_reg[DMA_OPT_BIT]);

    // shadow follows only accepted writes, lane by lane
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctl) begin
            if (i_avs_byteenable[0]) ctrl_reg[7:0] <= i_avs_writedata[7:0];
            if (i_avs_byteenable[1]) ctrl_reg[15:8] <= i_avs_writedata[15:8];
        end
    end

    // expected layout; 110 decodes as normal since it is never used
    always_comb begin
        case (ctrl_reg[SEL_MSB:SEL_LSB])
            SEL_AREA2:      exp_space = 7'h08;
            SEL_AREA23:     exp_space = 7'h18;
            SEL_AREA2TO5:   exp_space = 7'h78;
            SEL_CONT_SDRAM: exp_space = SDRAM_SUPPORT ? 7'h7a : 7'h00;
            SEL_SDRAM_MODE: exp_space = SDRAM_SUPPORT ? 7'h01 : 7'h00;
            SEL_CONT_DRAM:  exp_space = 7'h7c;
            default:        exp_space = 7'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // properties
    sequence s_dram_start;
        i_access.start && hit;
    endsequence
    sequence s_dram_end;
        i_access.done && o_access_dram;
    endsequence

    AST_SEL_DECODE: assert property (o_space == exp_space)
        else $error("space layout differs from select field");
    AST_DRAM_FLAG: assert property (i_access.start |=> o_access_dram == $past(hit))
        else $error("dram flag wrong after access start");
    AST_STROBE_ACT: assert property (s_dram_start |=> !o_row_strobe_b)
        else $error("row strobe not low in dram access");
    AST_BURST_GRANT: assert property (s_dram_start ##0 grant |=> o_burst_ok)
        else $error("burst not granted");
    AST_BURST_FULL: assert property (i_access.start && !grant |=> !o_burst_ok)
        else $error("burst granted while full access required");
    AST_HOLD: assert property (s_dram_end ##0 (be && ctrl_reg[HOLD_BIT] && !o_space.cont_sdram)
        |=> !o_row_strobe_b && o_row_held)
        else $error("row strobe not held low");
    AST_HELD_KEEP: assert property (o_row_held && i_access.start && !hit |=> o_row_held)
        else $error("hold lost on normal access");
    AST_UP_MODE: assert property (s_dram_end ##0 !(be && ctrl_reg[HOLD_BIT])
        |=> o_row_strobe_b && !o_row_held)
        else $error("row strobe not lifted in up mode");
    AST_HOLD_DROP: assert property (o_row_held && wr_ctl && i_avs_byteenable[0]
        && !i_avs_writedata[HOLD_BIT] |-> ##[1:2] (o_row_strobe_b && !o_row_held))
        else $error("hold not dropped after clearing");
    AST_CSDRAM_HOLD: assert property (s_dram_end ##0 o_space.cont_sdram |=> o_row_strobe_b)
        else $error("hold applied in continuous sdram space");
endmodule

bind dsbc_top dsbc_top_chk #(.SDRAM_SUPPORT(SDRAM_SUPPORT)) dsbc_top_chk_i (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_access(i_access), .o_space(o_space),
    .o_access_dram(o_access_dram), .o_burst_ok(o_burst_ok),
    .o_row_strobe_b(o_row_strobe_b), .o_row_held(o_row_held));

/* File: tb/dsbc_mem_model.sv */
// bus-side partner: issues external accesses and records the answers
`timescale 1ns/1ps
module dsbc_mem_model (
    input  wire logic             i_sys_clk,  // clock
    input  wire logic             i_rst_b,    // reset, low
    input  wire logic             i_go,       // launch one access
    input  wire logic [2:0]       i_area,     // target area
    input  wire logic             i_dma,      // single-address dma transfer
    input  wire logic             i_dram,     // dram flag from the block
    input  wire logic             i_burst,    // burst grant from the block
    input  wire logic             i_strobe_b, // row strobe from the block
    output dsbc_pkg::dsbc_access_t o_access,  // access towards the block
    output logic                  o_busy,     // access in flight
    output logic [2:0]            o_seen      // dram, burst, strobe in answer cycle
);
    import dsbc_pkg::*;
    logic [1:0] phase;

    assign o_busy = (phase != 2'h0);

    // start one cycle, done the next; edo output enable assumed wired
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase <= 2'h0;
            o_access <= '0;
            o_seen <= 3'h0;
        end else case (phase)
            2'h0: if (i_go) begin
                phase <= 2'h1;
                o_access <= '{1'b1, 1'b0, i_area, i_dma, 1'b0};
            end
            2'h1: begin
                phase <= 2'h2;
                o_access.start <= 1'b0;
                o_access.done <= 1'b1;
            end
            default: begin
                // released lines flip so a stale value cannot pass
                phase <= 2'h0;
                o_access.done <= 1'b0;
                o_access.area <= ~o_access.area;
                o_access.dma_single <= ~o_access.dma_single;
                o_seen <= {i_dram, i_burst, i_strobe_b};
            end
        endcase
    end
endmodule

/* File: tb/dsbc_bench.sv */
// self-checking bench for the dram space and burst configuration block
`timescale 1ns/1ps
module dsbc_bench;
    import dsbc_pkg::*;
    logic         sys_clk, rst_b, rd_q, wr_q, go, dma_s, busy;
    logic         acc_dram, burst_ok, strobe_b, held, waitreq;
    logic [3:0]   addr;
    logic [31:0]  wdata, rdata;
    logic [2:0]   tgt, seen;
    dsbc_access_t access;
    dsbc_space_t  space;
    int           n_errors, samples_checked;
    logic [6:0]   exp_space [8] = '{7'h00, 7'h08, 7'h18, 7'h78, 7'h7a, 7'h01, 7'h00, 7'h7c};
    logic [3:0]   dma_tab [4] = '{4'ha, 4'hf, 4'h6, 4'h9}; // burst en, dma opt, dma, burst

    dsbc_top dsbc_top_i (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_avs_address(addr),
        .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_access(access), .o_space(space), .o_access_dram(acc_dram),
        .o_burst_ok(burst_ok), .o_row_strobe_b(strobe_b), .o_row_held(held));
    dsbc_mem_model dsbc_mem_model_i (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_go(go),
        .i_area(tgt), .i_dma(dma_s), .i_dram(acc_dram), .i_burst(burst_ok), .i_strobe_b(strobe_b),
        .o_access(access), .o_busy(busy), .o_seen(seen));

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog; a whole run needs well under a thousand cycles
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        rd_q <= ~w;
        wr_q <= w;
        addr <= a;
        wdata <= d;
        do @(posedge sys_clk); while (waitreq !== 1'b0);
        q = rdata;
        rd_q <= 1'b0;
        wr_q <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string w);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e, w);
    endtask
    // one external access; e is dram flag, burst grant, strobe level
    task automatic acc(input logic [2:0] a, input logic d, input logic [2:0] e);
        @(posedge sys_clk);
        go <= 1'b1;
        tgt <= a;
        dma_s <= d;
        @(posedge sys_clk);
        go <= 1'b0;
        do @(negedge sys_clk); while (busy !== 1'b0);
        chk({29'h0, seen}, {29'h0, e}, "access answer");
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] s, input logic b, input logic h,
                                        input logic d);
        return {16'h0, 5'h0, s, b, h, d, 5'h0};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        n_errors = 0;
        samples_checked = 0;
        {rst_b, rd_q, wr_q, go, dma_s, addr, wdata, tgt} = '0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFF_CONTROL, 32'h0, "control reset");
        rd(OFF_STATUS, 32'h0, "status reset");
        chk({31'h0, strobe_b}, 32'h1, "strobe at reset");
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            if (s == 6) continue; // prohibited code is never written
            wr(OFF_CONTROL, ctl(3'(s), 1'b0, 1'b0, 1'b0));
            @(negedge sys_clk);
            chk({25'h0, space}, {25'h0, exp_space[s]}, "decode");
            rd(OFF_CONTROL, ctl(3'(s), 1'b0, 1'b0, 1'b0), "control readback");
        end
        $display("test decode done");
        wr(OFF_CONTROL, ctl(3'h1, 1'b0, 1'b0, 1'b0));
        acc(3'h2, 1'b0, 3'h4);
        acc(3'h3, 1'b0, 3'h1);
        wr(OFF_CONTROL, ctl(3'h1, 1'b1, 1'b0, 1'b0));
        acc(3'h2, 1'b0, 3'h6);
        $display("test burst done");
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CONTROL, ctl(3'h3, dma_tab[i][3], 1'b0, dma_tab[i][2]));
            acc(3'h5, dma_tab[i][1], {1'b1, dma_tab[i][0], 1'b0});
        end
        $display("test dma done");
        wr(OFF_CONTROL, ctl(3'h1, 1'b1, 1'b1, 1'b0));
        acc(3'h2, 1'b0, 3'h6);
        @(negedge sys_clk);
        chk({30'h0, strobe_b, held}, 32'h1, "strobe held after dram");
        acc(3'h4, 1'b0, 3'h0);
        rd(OFF_STATUS, 32'h13, "status while held");
        wr(OFF_CONTROL, ctl(3'h1, 1'b1, 1'b0, 1'b0));
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({30'h0, strobe_b, held}, 32'h2, "hold cleared by write");
        wr(OFF_CONTROL, ctl(3'h1, 1'b0, 1'b1, 1'b0));
        acc(3'h2, 1'b0, 3'h4);
        @(negedge sys_clk);
        chk({30'h0, strobe_b, held}, 32'h2, "hold ignored without burst");
        $display("test hold done");
        wr(OFF_CONTROL, ctl(3'h4, 1'b1, 1'b1, 1'b0));
        acc(3'h3, 1'b0, 3'h6);
        @(negedge sys_clk);
        chk({30'h0, strobe_b, held}, 32'h2, "no hold in cont sdram");
        rd(OFF_CONTROL, ctl(3'h4, 1'b1, 1'b1, 1'b0), "hold bit kept");
        $display("test sdram done");
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, 32'h0, "unmapped read");
        wr(OFF_STATUS, 32'hffff_ffff);
        rd(OFF_STATUS, 32'h2f0, "status read only");
        rd(OFF_CONTROL, ctl(3'h4, 1'b1, 1'b1, 1'b0), "control untouched");
        $display("test map done");
        report_and_stop();
    end
endmodule
